// ==== core/adcc_accum.v ====
// sample truncation and accumulation over 1..64 samples
`timescale 1ns/1ps
module adcc_accum (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        clear,
  input  wire        sample_valid,
  input  wire [9:0]  sample,
  input  wire        eight_bit,
  input  wire [2:0]  count_code,
  output reg  [15:0] sum,
  output reg         done
);
  reg  [6:0] taken;
  wire [9:0] value = eight_bit ? {2'b00, sample[9:2]} : sample;
  wire [6:0] needed = 7'h01 << count_code;
  wire [15:0] base  = (taken == 7'h00) ? 16'h0000 : sum;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sum   <= 16'h0000;
      taken <= 7'h00;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (clear) begin
        taken <= 7'h00;
      end else if (sample_valid) begin
        sum <= base + {6'h00, value};
        if (taken + 7'h01 >= needed) begin
          taken <= 7'h00;
          done  <= 1'b1;
        end else begin
          taken <= taken + 7'h01;
        end
      end
    end
  end
endmodule

// ==== core/adcc_defines.vh ====
// register indices, field positions and encodings of the converter control
`ifndef ADCC_DEFINES_VH
`define ADCC_DEFINES_VH

`define ADCC_IDX_CONTROL_A  8'h00
`define ADCC_IDX_ACCUM      8'h01
`define ADCC_IDX_REFCLK     8'h02
`define ADCC_IDX_DELAYS     8'h03
`define ADCC_IDX_WINMODE    8'h04
`define ADCC_IDX_SAMPLE_LEN 8'h05
`define ADCC_IDX_INSEL      8'h06
`define ADCC_IDX_COMMAND    8'h08
`define ADCC_IDX_EVENT      8'h09
`define ADCC_IDX_INTEN      8'h0A
`define ADCC_IDX_FLAGS      8'h0B
`define ADCC_IDX_DEBUG      8'h0C
`define ADCC_IDX_SCRATCH    8'h0D
`define ADCC_IDX_RESULT     8'h10
`define ADCC_IDX_WINLO      8'h12
`define ADCC_IDX_WINHI      8'h14
`define ADCC_IDX_TRIM       8'h16

`define ADCC_CONTROL_A_MASK 8'h87
`define ADCC_BIT_ENABLE     0
`define ADCC_BIT_FREE_RUN   1
`define ADCC_BIT_RES_SELECT 2
`define ADCC_BIT_RUN_STBY   7
`define ADCC_ACCUM_MASK     8'h07
`define ADCC_REFCLK_MASK    8'h77
`define ADCC_BIT_CAP_SELECT 6
`define ADCC_WINMODE_MASK   8'h07
`define ADCC_SAMPLE_LEN_MASK 8'h1F
`define ADCC_INSEL_MASK     8'h1F
`define ADCC_BIT1_MASK      8'h01
`define ADCC_INT_MASK       8'h03
`define ADCC_FLAG_READY     0
`define ADCC_FLAG_WINDOW    1
`define ADCC_RESET_VAL      8'h00

`define ADCC_WIN_NONE       3'h0
`define ADCC_WIN_BELOW      3'h1
`define ADCC_WIN_ABOVE      3'h2
`define ADCC_WIN_INSIDE     3'h3
`define ADCC_WIN_OUTSIDE    3'h4

`endif

// ==== core/adcc_divider.v ====
// converter clock enable: one pulse every 2^(code+1) peripheral clocks
`timescale 1ns/1ps
module adcc_divider (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       run,
  input  wire [2:0] code,
  output reg        tick
);
  reg  [7:0] count;
  wire [7:0] last = (8'h02 << code) - 8'h01;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 8'h00;
      tick  <= 1'b0;
    end else if (!run) begin
      count <= 8'h00;
      tick  <= 1'b0;
    end else if (count >= last) begin
      count <= 8'h00;
      tick  <= 1'b1;
    end else begin
      count <= count + 8'h01;
      tick  <= 1'b0;
    end
  end
endmodule

// ==== core/adcc_top.v ====
// converter control block: apb registers, sequencing, window, interrupts
`timescale 1ns/1ps
`include "adcc_defines.vh"

////////////////////////////////////////////////////////////////////////////
// Contract
// - converter runs only while enabled
// - run-in-standby bit keeps converter running in standby
// - ten-bit values stored when resolution clear
// - resolution set drops two lowest bits
// - free running starts on start command
// - free running restarts after each completion
// - accumulation code selects 1 to 64 samples
// - accumulated sum counts as one conversion
// - cap bit picks reduced sampling capacitor
// - reference code picks internal or supply
// - divider gives peripheral clock over 2^(code+1)
// - completion sets ready flag, clears start
// - interrupt while flag and enable set
// - event rising edge starts conversion when enabled
// - window compared once after last sample
module adcc_top #(
  parameter CONV_TICKS = 13
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        standby,
  input  wire        debug_halt,
  input  wire        start_event,
  input  wire [9:0]  sample_data,
  output reg         converter_on,
  output reg         sample_start,
  output reg  [4:0]  input_select,
  output reg         sample_cap_select,
  output reg  [1:0]  reference_select,
  output reg         irq
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg  [7:0]  control_a;
  reg  [7:0]  control_b_accumulation;
  reg  [7:0]  control_c_reference_clock;
  reg  [7:0]  control_d_delays;
  reg  [7:0]  control_e_window_mode;
  reg  [7:0]  sample_length;
  reg  [7:0]  input_sel;
  reg         start_conversion;
  reg         start_event_input;
  reg  [1:0]  interrupt_enable;
  reg  [1:0]  interrupt_flags;
  reg         run_in_debug;
  reg  [7:0]  byte_scratch;
  reg  [15:0] conversion_result;
  reg  [15:0] window_low_threshold;
  reg  [15:0] window_high_threshold;
  reg         sampling_duty;

  wire enable          = control_a[`ADCC_BIT_ENABLE];
  wire free_running    = control_a[`ADCC_BIT_FREE_RUN];
  wire resolution_select = control_a[`ADCC_BIT_RES_SELECT];
  wire run_in_standby  = control_a[`ADCC_BIT_RUN_STBY];
  wire [2:0] accumulation_count = control_b_accumulation[2:0];
  wire [2:0] clock_divider = control_c_reference_clock[2:0];
  wire [2:0] window_mode = control_e_window_mode[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg [2:0] ev_sync;
  reg [1:0] sb_sync;
  reg [1:0] dbg_sync;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_sync  <= 3'h0;
      sb_sync  <= 2'h0;
      dbg_sync <= 2'h0;
    end else begin
      ev_sync  <= {ev_sync[1:0], start_event};
      sb_sync  <= {sb_sync[0], standby};
      dbg_sync <= {dbg_sync[0], debug_halt};
    end
  end

  // edge detect reads only the second and third stages
  wire event_rise = ev_sync[1] & ~ev_sync[2];
  wire event_start = start_event_input & event_rise & enable;

  // standby stops the converter unless run-in-standby is set
  wire active = enable & (~sb_sync[1] | run_in_standby)
              & (~dbg_sync[1] | run_in_debug);

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  wire access   = psel & penable;
  wire wr       = access & pwrite;
  wire [7:0] wb = pwdata[7:0];
  wire [7:0] wh = pwdata[15:8];
  // each register is one aligned word: byte address is four times its index
  wire [7:0] reg_index = {2'b00, paddr[7:2]};
  wire       aligned   = (paddr[1:0] == 2'b00);
  wire mapped;
  reg  [15:0] next_rdata;
  reg         next_mapped;

  always @* begin
    next_rdata  = 16'h0000;
    next_mapped = 1'b1;
    if (reg_index == `ADCC_IDX_CONTROL_A)
      next_rdata = {8'h00, control_a};
    else if (reg_index == `ADCC_IDX_ACCUM)
      next_rdata = {8'h00, control_b_accumulation};
    else if (reg_index == `ADCC_IDX_REFCLK)
      next_rdata = {8'h00, control_c_reference_clock};
    else if (reg_index == `ADCC_IDX_DELAYS)
      next_rdata = {8'h00, control_d_delays};
    else if (reg_index == `ADCC_IDX_WINMODE)
      next_rdata = {8'h00, control_e_window_mode};
    else if (reg_index == `ADCC_IDX_SAMPLE_LEN)
      next_rdata = {8'h00, sample_length};
    else if (reg_index == `ADCC_IDX_INSEL)
      next_rdata = {8'h00, input_sel};
    else if (reg_index == `ADCC_IDX_COMMAND)
      next_rdata = {15'h0000, start_conversion};
    else if (reg_index == `ADCC_IDX_EVENT)
      next_rdata = {15'h0000, start_event_input};
    else if (reg_index == `ADCC_IDX_INTEN)
      next_rdata = {14'h0000, interrupt_enable};
    else if (reg_index == `ADCC_IDX_FLAGS)
      next_rdata = {14'h0000, interrupt_flags};
    else if (reg_index == `ADCC_IDX_DEBUG)
      next_rdata = {15'h0000, run_in_debug};
    else if (reg_index == `ADCC_IDX_SCRATCH)
      next_rdata = {8'h00, byte_scratch};
    else if (reg_index == `ADCC_IDX_RESULT)
      next_rdata = conversion_result;
    else if (reg_index == `ADCC_IDX_WINLO)
      next_rdata = window_low_threshold;
    else if (reg_index == `ADCC_IDX_WINHI)
      next_rdata = window_high_threshold;
    else if (reg_index == `ADCC_IDX_TRIM)
      next_rdata = {15'h0000, sampling_duty};
    else
      next_mapped = 1'b0;
  end
  // unaligned addresses answer like unmapped ones
  assign mapped = next_mapped & aligned;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite & mapped) ?
                 {16'h0000, next_rdata} : 32'h00000000;
    end
  end

  // writes land in the access cycle, which is the pready edge
  wire wr_hit = wr & pready & aligned;

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  localparam S_IDLE = 2'b00;
  localparam S_CONV = 2'b01;
  localparam S_WAIT = 2'b10;

  reg  [1:0] state;
  reg  [7:0] conv_count;
  reg        sample_valid;
  wire       adc_tick;
  wire [15:0] acc_sum;
  wire       acc_done;

  adcc_divider u_div (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (active),
    .code  (clock_divider),
    .tick  (adc_tick)
  );

  adcc_accum u_acc (
    .clk          (clk),
    .rst_n        (rst_n),
    .clear        (~active | (state == S_IDLE)),
    .sample_valid (sample_valid),
    .sample       (sample_data),
    .eight_bit    (resolution_select),
    .count_code   (accumulation_count),
    .sum          (acc_sum),
    .done         (acc_done)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= S_IDLE;
      conv_count   <= 8'h00;
      sample_valid <= 1'b0;
      sample_start <= 1'b0;
    end else begin
      sample_valid <= 1'b0;
      sample_start <= 1'b0;
      if (!active) begin
        state <= S_IDLE;
      end else begin
        case (state)
          S_IDLE: begin
            if (start_conversion) begin
              state        <= S_CONV;
              conv_count   <= 8'h00;
              sample_start <= 1'b1;
            end
          end
          S_CONV: begin
            if (adc_tick) begin
              if (conv_count >= CONV_TICKS[7:0] - 8'h01) begin
                sample_valid <= 1'b1;
                state        <= S_WAIT;
              end else begin
                conv_count <= conv_count + 8'h01;
              end
            end
          end
          S_WAIT: begin
            if (acc_done) begin
              // free running chains straight on
              state <= free_running ? S_CONV : S_IDLE;
              sample_start <= free_running;
              conv_count <= 8'h00;
            end else if (!sample_valid) begin
              state        <= S_CONV; // next sample of an accumulation
              conv_count   <= 8'h00;
              sample_start <= 1'b1;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // window compare, once per finished accumulation
  reg win_hit;
  always @* begin
    case (window_mode)
      `ADCC_WIN_BELOW:  win_hit = acc_sum < window_low_threshold;
      `ADCC_WIN_ABOVE:  win_hit = acc_sum > window_high_threshold;
      `ADCC_WIN_INSIDE: win_hit = (acc_sum > window_low_threshold) &
                                  (acc_sum < window_high_threshold);
      `ADCC_WIN_OUTSIDE: win_hit = (acc_sum < window_low_threshold) |
                                   (acc_sum > window_high_threshold);
      default:          win_hit = 1'b0;
    endcase
  end

  wire done_evt  = acc_done & active;
  wire window_compare_evt = done_evt & win_hit;

  ////////////////////////////////////////////////////////////////////////////
  // register writes and hardware updates
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      control_a                 <= `ADCC_RESET_VAL;
      control_b_accumulation    <= `ADCC_RESET_VAL;
      control_c_reference_clock <= `ADCC_RESET_VAL;
      control_d_delays          <= `ADCC_RESET_VAL;
      control_e_window_mode     <= `ADCC_RESET_VAL;
      sample_length             <= `ADCC_RESET_VAL;
      input_sel                 <= `ADCC_RESET_VAL;
      start_conversion          <= 1'b0;
      start_event_input         <= 1'b0;
      interrupt_enable          <= 2'b00;
      interrupt_flags           <= 2'b00;
      run_in_debug              <= 1'b0;
      byte_scratch              <= `ADCC_RESET_VAL;
      conversion_result         <= 16'h0000;
      window_low_threshold      <= 16'h0000;
      window_high_threshold     <= 16'h0000;
      sampling_duty             <= 1'b0;
    end else begin
      if (wr_hit) begin
        if (reg_index == `ADCC_IDX_CONTROL_A)
          control_a <= wb & `ADCC_CONTROL_A_MASK;
        else if (reg_index == `ADCC_IDX_ACCUM)
          control_b_accumulation <= wb & `ADCC_ACCUM_MASK;
        else if (reg_index == `ADCC_IDX_REFCLK)
          control_c_reference_clock <= wb & `ADCC_REFCLK_MASK;
        else if (reg_index == `ADCC_IDX_DELAYS)
          control_d_delays <= wb;
        else if (reg_index == `ADCC_IDX_WINMODE)
          control_e_window_mode <= wb & `ADCC_WINMODE_MASK;
        else if (reg_index == `ADCC_IDX_SAMPLE_LEN)
          sample_length <= wb & `ADCC_SAMPLE_LEN_MASK;
        else if (reg_index == `ADCC_IDX_INSEL)
          input_sel <= wb & `ADCC_INSEL_MASK;
        else if (reg_index == `ADCC_IDX_EVENT)
          start_event_input <= wb[0];
        else if (reg_index == `ADCC_IDX_INTEN)
          interrupt_enable <= wb[1:0];
        else if (reg_index == `ADCC_IDX_DEBUG)
          run_in_debug <= wb[0];
        else if (reg_index == `ADCC_IDX_SCRATCH)
          byte_scratch <= wb;
        else if (reg_index == `ADCC_IDX_WINLO)
          window_low_threshold <= {wh, wb};
        else if (reg_index == `ADCC_IDX_WINHI)
          window_high_threshold <= {wh, wb};
        else if (reg_index == `ADCC_IDX_TRIM)
          sampling_duty <= wb[0];
      end

      // start: write one or event edge sets, completion clears
      if (done_evt & ~free_running)
        start_conversion <= 1'b0;
      else if (done_evt & free_running & ~enable)
        start_conversion <= 1'b0;
      if ((wr_hit & (reg_index == `ADCC_IDX_COMMAND) & wb[0] & enable)
          | event_start)
        start_conversion <= 1'b1;
      if (done_evt & free_running)
        start_conversion <= 1'b0;

      if (done_evt)
        conversion_result <= acc_sum;

      // set wins over a same-cycle write-one clear
      interrupt_flags <= (interrupt_flags
                         & ~((wr_hit & (reg_index == `ADCC_IDX_FLAGS))
                             ? wb[1:0] : 2'b00))
                         | {window_compare_evt, done_evt};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      converter_on      <= 1'b0;
      input_select      <= 5'h00;
      sample_cap_select <= 1'b0;
      reference_select  <= 2'b00;
      irq               <= 1'b0;
    end else begin
      converter_on      <= active;
      input_select      <= input_sel[4:0];
      sample_cap_select <=
        control_c_reference_clock[`ADCC_BIT_CAP_SELECT];
      reference_select  <= control_c_reference_clock[5:4];
      irq <= |(interrupt_flags & interrupt_enable);
    end
  end

endmodule

// ==== verif/adcc_monitor.sv ====
// assertion checker on the converter control block ports
`timescale 1ns/1ps
module adcc_monitor #(
  parameter CONV_TICKS = 13
) (
  input wire        clk,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        converter_on,
  input wire        sample_start,
  input wire        sample_cap_select,
  input wire [1:0]  reference_select,
  input wire        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire wr     = psel && penable && pwrite && pready;
  wire irq_wr = wr && (paddr == 8'h28 || paddr == 8'h2C);
  ////////////////////////////////////////////////////////////////////////
  a_setup_answer: assert property (psel && !penable |=> pready)
    else $error("no answer in access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_ready: assert property (pslverr |-> pready && !pwrite || pready)
    else $error("error without ready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  // irq may only drop after software touches flags or enables
  a_irq_hold: assert property ($fell(irq) |->
    $past(irq_wr) || $past(irq_wr, 2))
    else $error("irq dropped without clear");
  a_sample_on: assert property (sample_start |-> converter_on)
    else $error("sample while converter off");
  a_sample_pulse: assert property (sample_start |=> !sample_start)
    else $error("sample start not a pulse");
  a_ref_write: assert property (!$stable(reference_select) |->
    $past(wr) || $past(wr, 2))
    else $error("reference changed without write");
  a_cap_write: assert property (!$stable(sample_cap_select) |->
    $past(wr) || $past(wr, 2))
    else $error("cap select changed without write");
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
  c_samp: cover property (sample_start ##[1:300] sample_start);
endmodule

bind adcc_top adcc_monitor #(.CONV_TICKS(CONV_TICKS)) adcc_monitor_inst (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .converter_on(converter_on),
  .sample_start(sample_start), .sample_cap_select(sample_cap_select),
  .reference_select(reference_select), .irq(irq));

// ==== verif/tb_top.sv ====
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top;
  // short conversion keeps 64-sample runs fast
  localparam CT = 3;
  // register index shifted to its byte address
  localparam logic [7:0] RA = 8'h00 << 2, RB = 8'h01 << 2, RC = 8'h02 << 2;
  localparam logic [7:0] RE = 8'h04 << 2, RCMD = 8'h08 << 2, REV = 8'h09 << 2;
  localparam logic [7:0] RIE = 8'h0A << 2, RFL = 8'h0B << 2, RIN = 8'h06 << 2;
  localparam logic [7:0] RRES = 8'h10 << 2, RWL = 8'h12 << 2, RNM = 8'h07 << 2;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        standby = 0, start_event = 0, pready, pslverr, er;
  logic        converter_on, sample_start, sample_cap_select, irq;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [9:0]  sample_data = 0;
  logic [4:0]  input_select;
  logic [1:0]  reference_select;
  int          n_fail = 0, checked = 0, cyc = 0, n_samp = 0;
  int          last = 0, gap = 0;

  adcc_top #(.CONV_TICKS(CT)) adcc_top_inst (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .standby(standby),
    .debug_halt(1'b0), .start_event(start_event),
    .sample_data(sample_data), .converter_on(converter_on),
    .sample_start(sample_start), .input_select(input_select),
    .sample_cap_select(sample_cap_select),
    .reference_select(reference_select), .irq(irq));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (sample_start === 1'b1) begin
      n_samp++;
      gap = cyc - last;
      last = cyc;
    end
    if (cyc == 40000) begin
      n_fail++;
      end_of_test;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // pre-edge values are read, so pready is seen as the edge samples it
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    apb(0, a, 0);
    check(nm, rd, e);
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    check("irq_seen", irq, 1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] ad[8] = '{RA, RB, RC, RE, RCMD, REV, RIE, RFL};
    logic [7:0] wv[4] = '{8'hFF, 8'hFE, 8'hDF, 8'hFC};
    logic [7:0] ev[4] = '{8'h87, 8'h06, 8'h57, 8'h04};
    foreach (ad[i]) rdc("reset", ad[i], 0);
    foreach (wv[i]) begin
      wr(ad[i], wv[i]);
      rdc("mask", ad[i], ev[i]);
    end
    check("ref_vdd", {30'h0, reference_select}, 1);
    check("cap_small", sample_cap_select, 1);
    foreach (wv[i]) wr(ad[i], 0);
    check("ref_int", {30'h0, reference_select}, 0);
    check("cap_norm", sample_cap_select, 0);
    wr(RIN, 32'hFF);
    rdc("insel", RIN, 32'h1F);
    check("insel_pin", {27'h0, input_select}, 32'h1F);
    wr(RIN, 0);
    apb(1, RNM, 32'hFF);
    check("unmapped_err", er, 1);
    rdc("unmapped", RNM, 0);
    wr(RRES, 32'h1234);
    rdc("result_ro", RRES, 0);
  endtask

  task automatic conv(input logic [7:0] ca, cb, input logic [9:0] s,
                      input logic [15:0] e, input int ns, fl);
    sample_data <= s;
    wr(RB, cb);
    wr(RA, ca);
    wr(RIE, 1);
    n_samp = 0;
    wr(RCMD, 1);
    wait_irq;
    check("samples", n_samp, ns);
    rdc("result", RRES, e);
    rdc("command", RCMD, 0);
    rdc("flags", RFL, fl);
    wr(RFL, 3);
    @(posedge clk);
    check("irq_low", irq, 0);
  endtask

  task automatic t_conv;
    conv(1, 0, 10'h2AB, 16'h02AB, 1, 1);
    conv(5, 0, 10'h2AB, 16'h00AA, 1, 1);
    // codes 0 to 6 only, 7 is left alone
    for (int c = 0; c < 7; c++)
      conv(1, c, 10'h3FF, 16'h3FF << c, 1 << c, 1);
  endtask

  // first sample alone is below 0x18, the final sum is not
  task automatic t_window;
    wr(RE, 1);
    wr(RWL, 32'h0018);
    conv(1, 1, 10'h010, 16'h0020, 2, 1);
    wr(RWL, 32'h0100);
    conv(1, 1, 10'h010, 16'h0020, 2, 3);
    wr(RE, 0);
  endtask

  task automatic t_free;
    for (int p = 0; p < 3; p++) begin
      wr(RC, p);
      wr(RB, 0);
      n_samp = 0;
      wr(RA, 3);
      repeat (50) @(posedge clk);
      check("no_start", n_samp, 0);
      wr(RCMD, 1);
      wait_irq;
      wr(RFL, 1);
      @(posedge clk);
      wait_irq;
      check("gap", gap >= CT * (2 << p) &&
            gap <= CT * (2 << p) + (2 << p) + 8, 1);
      wr(RA, 0);
      repeat (300) @(posedge clk);
      wr(RFL, 3);
    end
    wr(RC, 0);
  endtask

  task automatic t_event;
    wr(RCMD, 1);
    repeat (100) @(posedge clk);
    rdc("off_flag", RFL, 0);
    check("off", converter_on, 0);
    wr(RA, 1);
    @(posedge clk);
    check("on", converter_on, 1);
    start_event <= 1;
    repeat (100) @(posedge clk);
    rdc("no_event", RFL, 0);
    start_event <= 0;
    wr(REV, 1);
    start_event <= 1;
    wait_irq;
    start_event <= 0;
    wr(RFL, 3);
    wr(REV, 0);
  endtask

  task automatic t_standby;
    standby <= 1;
    repeat (5) @(posedge clk);
    check("stby_off", converter_on, 0);
    wr(RA, 32'h81);
    repeat (5) @(posedge clk);
    check("stby_on", converter_on, 1);
    standby <= 0;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    t_regs;
    t_conv;
    t_window;
    t_free;
    t_event;
    t_standby;
    end_of_test;
  end
endmodule
